// *** baud_divider.sv ***
`timescale 1ns/100ps
module baud_divider #(
   parameter int WIDTH = 16
) (
   // clock and control
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // source ticks and divisor
   input wire logic src_tick,
   input wire logic [WIDTH-1:0] divisor,
   output logic tick
);
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH:0] seen_r;
   logic clean_r;
   logic [WIDTH-1:0] div_prev_r;

   // zero stops the output, one passes the source straight through
   wire is_off = (divisor == '0);
   wire is_bypass = (divisor == WIDTH'(1));
   wire at_end = (cnt_r >= divisor - WIDTH'(1));

   assign tick = src_tick & ~is_off & (is_bypass | at_end);

   // count source ticks, wrap on the last one
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= '0;
      end else if (ce && src_tick) begin
         if (at_end || is_off || is_bypass) cnt_r <= '0;
         else cnt_r <= cnt_r + WIDTH'(1);
      end
   end

   // checking aid: source ticks since the last output tick
   always_ff @(posedge clk) begin
      if (srst) begin
         seen_r <= '0;
         clean_r <= 1'b0;
         div_prev_r <= '0;
      end else if (ce) begin
         div_prev_r <= divisor;
         if (tick) seen_r <= '0;
         else if (src_tick) seen_r <= seen_r + (WIDTH+1)'(1);
         if (divisor != div_prev_r) clean_r <= 1'b0;
         else if (tick) clean_r <= 1'b1;
      end
   end

   AST_DIV_ZERO: assert property (@(posedge clk) disable iff (srst)
      divisor == '0 |-> !tick)
      else $error("tick produced with zero divisor");
   AST_DIV_BYPASS: assert property (@(posedge clk) disable iff (srst)
      divisor == WIDTH'(1) |-> tick == src_tick)
      else $error("divisor one does not pass source");
   AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (srst)
      ce && tick && divisor > WIDTH'(1) && clean_r
      && divisor == div_prev_r |-> seen_r + 1 == divisor)
      else $error("divider period differs from divisor");
endmodule

// *** sck_sync.sv ***
`timescale 1ns/100ps
module sck_sync (
   // clock and control
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // pin and result
   input wire logic pin,
   output logic rise
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;
   logic rise_r;

   // a change counts only once the last two stages agree
   wire agree = (s2_r == s3_r);
   wire rise_nxt = s2_r & s3_r & ~lvl_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
         rise_r <= 1'b0;
      end else if (ce) begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) lvl_r <= s3_r;
         rise_r <= rise_nxt;
      end
   end

   assign rise = rise_r;

   AST_SYNC_ONCE: assert property (@(posedge clk) disable iff (srst)
      ce && rise_r ##1 ce |-> !rise_r)
      else $error("pin edge counted twice");
   AST_SYNC_RISE: assert property (@(posedge clk) disable iff (srst)
      ce && rise_nxt |=> rise_r && lvl_r)
      else $error("agreed pin edge lost");
endmodule

// *** serial_far_end.sv ***
`timescale 1ns/100ps
// ------------------------------------
// far-end serial device
// ------------------------------------
module serial_far_end (
   // system side
   input wire logic clk,
   input wire logic run,
   input wire logic [5:0] fault,
   // line side
   output logic sck,
   output logic [5:0] err_set
);
   logic [1:0] ph_r;
   initial begin
      sck = 1'b0;
      ph_r = 2'h0;
      err_set = 6'h00;
   end
   // 4 cycles a phase: slow enough for the 3-flop sync; parked low idle
   always @(posedge clk) begin
      ph_r <= run ? ph_r + 2'h1 : 2'h0;
      if (!run)
         sck <= 1'b0;
      else if (ph_r == 2'h3)
         sck <= ~sck;
   end
   // line faults only when the bench asks for them
   always @(posedge clk) err_set <= fault;
endmodule

// *** test_usart_baud_and_control.sv ***
`timescale 1ns/100ps
`include "usart_defines.svh"
module test_usart_baud_and_control;
   logic CLK_SYS, SRST, CLK_EN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic [31:0] AWADDR, WDATA, ARADDR, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SCK_IN;
   logic RX_ENABLE, TX_ENABLE, RX_RESET, TX_RESET, SAMPLE_TICK, BAUD_TICK;
   logic [5:0] ERR_SET, fault;
   logic run;
   int mismatches, checks_done, rx_pulses, tx_pulses, orphans;
   localparam logic [31:0] cmd_words [7] = '{32'h50, 32'h0, 32'hFFFFFE03,
      32'h30, 32'h10, 32'hC0, 32'h20};
   localparam logic [1:0] en_want [7] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h3,
      2'h2, 2'h0};
   localparam logic [31:0] modes [7] = '{32'h0, 32'h0, 32'h80000, 32'h0,
      32'h0, 32'h80010, 32'h20};
   localparam logic [31:0] divs [7] = '{32'h0, 32'h1, 32'h1, 32'h5,
      32'h10003, 32'h2, 32'h1};
   localparam int samples [7] = '{0, 480, 480, 96, 160, 30, 60};

   usart_baud_and_control i_dut (.CLK_SYS, .SRST, .CLK_EN, .AWADDR,
      .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
      .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
      .RVALID, .RREADY, .SCK_IN, .ERR_SET, .RX_ENABLE, .TX_ENABLE,
      .RX_RESET, .TX_RESET, .SAMPLE_TICK, .BAUD_TICK);
   serial_far_end i_far (.clk(CLK_SYS), .run, .fault, .sck(SCK_IN),
      .err_set(ERR_SET));

   // ------------------------------------
   // clock, watchers and checks
   // ------------------------------------
   initial begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   // pulses are counted here, as they may fall before a task looks
   always @(negedge CLK_SYS) begin
      if (RX_RESET === 1'b1) rx_pulses++;
      if (TX_RESET === 1'b1) tx_pulses++;
      if (BAUD_TICK === 1'b1 && SAMPLE_TICK !== 1'b1) orphans++;
   end
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task check(input logic [31:0] got, want);
      checks_done++;
      if (got !== want) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // tick counts may slip by one at the window edges
   task near(input int got, want);
      checks_done++;
      if (got < want - (want != 0) || got > want + (want != 0)) begin
         mismatches++;
         $display("mismatch at %0t: ticks %0d want %0d", $time, got, want);
      end
   endtask
   task timeout;
      mismatches++;
      $display("mismatch at %0t: bus answer missing", $time);
      complete_run;
   endtask
   // one write; valid and payload held until each is taken
   task wrchk(input logic [31:0] a, d, input logic [3:0] s,
      input logic [1:0] want);
      int i;
      @(posedge CLK_SYS);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge CLK_SYS);
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
         if (BVALID === 1'b1) break;
      end
      if (i == 64) timeout;
      check(BRESP, want);
      BREADY <= 1'b0;
   endtask
   task rdchk(input logic [31:0] a, want, input logic [1:0] rwant);
      int i;
      @(posedge CLK_SYS);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(posedge CLK_SYS);
         if (ARREADY === 1'b1) ARVALID <= 1'b0;
         if (RVALID === 1'b1) break;
      end
      if (i == 64) timeout;
      check(RDATA, want);
      check(RRESP, rwant);
      RREADY <= 1'b0;
   endtask

   // ------------------------------------
   // scenarios
   // ------------------------------------
   task t_bus;
      rdchk(`BAUD_ADDR, 32'h0, `RESP_OKAY);
      rdchk(`CMD_ADDR, 32'h0, `RESP_OKAY);
      rdchk(32'h4009_0008, 32'h0, `RESP_SLVERR);
      wrchk(32'h4009_000C, 32'h50, 4'hF, `RESP_SLVERR);
      wrchk(`STAT_ADDR, 32'h3F, 4'hF, `RESP_SLVERR);
      wrchk(`CMD_ADDR, 32'h50, 4'hE, `RESP_OKAY);
      rdchk(`STAT_ADDR, 32'h0, `RESP_OKAY);
   endtask
   task t_flags;
      for (int i = 0; i < 6; i++) begin
         @(posedge CLK_SYS);
         fault <= 6'h01 << i;
         @(posedge CLK_SYS);
         fault <= 6'h00;
         repeat (3) @(posedge CLK_SYS);
         wrchk(`CMD_ADDR, 32'h0, 4'hF, `RESP_OKAY);
         rdchk(`STAT_ADDR, 32'h1 << i, `RESP_OKAY);
         wrchk(`CMD_ADDR, 32'h100, 4'hF, `RESP_OKAY);
         rdchk(`STAT_ADDR, 32'h0, `RESP_OKAY);
      end
      // events held through the clearing write survive it: set wins
      @(posedge CLK_SYS);
      fault <= 6'h21;
      wrchk(`CMD_ADDR, 32'h100, 4'hF, `RESP_OKAY);
      rdchk(`STAT_ADDR, 32'h21, `RESP_OKAY);
      fault <= 6'h00;
      wrchk(`CMD_ADDR, 32'h100, 4'hF, `RESP_OKAY);
      rdchk(`STAT_ADDR, 32'h0, `RESP_OKAY);
   endtask
   task t_cmd;
      int r0, t0;
      for (int i = 0; i < 7; i++) begin
         wrchk(`CMD_ADDR, cmd_words[i], 4'hF, `RESP_OKAY);
         check({RX_ENABLE, TX_ENABLE}, en_want[i]);
         rdchk(`STAT_ADDR, {en_want[i][0], en_want[i][1], 8'h0},
            `RESP_OKAY);
      end
      for (int j = 0; j < 2; j++) begin
         r0 = rx_pulses;
         t0 = tx_pulses;
         wrchk(`CMD_ADDR, 32'h4 << j, 4'hF, `RESP_OKAY);
         repeat (4) @(posedge CLK_SYS);
         check(rx_pulses - r0, j == 0);
         check(tx_pulses - t0, j == 1);
      end
   endtask
   task t_ticks;
      int s, b;
      for (int i = 0; i < 7; i++) begin
         run <= modes[i][5];
         wrchk(`MODE_ADDR, modes[i], 4'hF, `RESP_OKAY);
         wrchk(`BAUD_ADDR, divs[i], 4'hF, `RESP_OKAY);
         repeat (40) @(posedge CLK_SYS);
         s = 0;
         b = 0;
         repeat (480) begin
            @(negedge CLK_SYS);
            if (SAMPLE_TICK === 1'b1) s++;
            if (BAUD_TICK === 1'b1) b++;
         end
         near(s, samples[i]);
         near(b, samples[i] / (modes[i][19] ? 8 : 16));
      end
      run <= 1'b0;
      check(orphans, 0);
   endtask

   // reset for 4 cycles, then the scenarios in turn
   initial begin
      {SRST, CLK_EN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h60;
      {AWADDR, WDATA, ARADDR, WSTRB} = 100'h0;
      fault = 6'h00;
      run = 1'b0;
      repeat (4) @(posedge CLK_SYS);
      SRST <= 1'b0;
      t_bus;
      t_flags;
      t_cmd;
      t_ticks;
      complete_run;
   end
endmodule

// *** usart_baud_and_control.sv ***
`timescale 1ns/100ps
`include "usart_defines.svh"
module usart_baud_and_control
   import usart_pkg::*;
#(
   parameter int DIV_WIDTH = 16
) (
   // clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic CLK_EN,
   // write address channel
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // write data channel
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // write response channel
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // read address channel
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // read data channel
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // serial clock pin and error events
   input wire logic SCK_IN,
   input wire logic [5:0] ERR_SET,
   // receiver and transmitter control
   output logic RX_ENABLE,
   output logic TX_ENABLE,
   output logic RX_RESET,
   output logic TX_RESET,
   output logic SAMPLE_TICK,
   output logic BAUD_TICK
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // expand byte strobes into a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction

   // split a command word into its actions
   function automatic cmd_t decode_cmd(input logic [31:0] d);
      cmd_t c;
      c.rx_reset = d[`RX_RESET_BIT];
      c.tx_reset = d[`TX_RESET_BIT];
      c.rx_on = d[`RX_ON_BIT];
      c.rx_off = d[`RX_OFF_BIT];
      c.tx_on = d[`TX_ON_BIT];
      c.tx_off = d[`TX_OFF_BIT];
      c.err_clear = d[`ERR_CLEAR_BIT];
      return c;
   endfunction

   // ----------------------------------------
   // bus state
   // ----------------------------------------
   wr_state_t wr_state_r;
   logic aw_got_r;
   logic w_got_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // ----------------------------------------
   // block state
   // ----------------------------------------
   mode_t mode_r;
   logic [DIV_WIDTH-1:0] divisor_r;
   logic rx_on_r;
   logic tx_on_r;
   logic rx_reset_r;
   logic tx_reset_r;
   err_flags_t flags_r;
   logic [2:0] pre_cnt_r;
   logic [3:0] os_cnt_r;
   logic sample_r;
   logic baud_r;

   // ----------------------------------------
   // write path decode
   // ----------------------------------------
   wire aw_fire = AWVALID & awready_r;
   wire w_fire = WVALID & wready_r;
   wire wr_apply = (wr_state_r == WR_IDLE) & aw_got_r & w_got_r;
   wire [31:0] wmask = strb_mask(wstrb_r);
   wire [31:0] wbits = wdata_r & wmask;
   wire hit_cmd = (awaddr_r == `CMD_ADDR);
   wire hit_mode = (awaddr_r == `MODE_ADDR);
   wire hit_baud = (awaddr_r == `BAUD_ADDR);
   wire wr_ok = hit_cmd | hit_mode | hit_baud;
   wire cmd_go = wr_apply & hit_cmd;
   wire mode_go = wr_apply & hit_mode;
   wire baud_go = wr_apply & hit_baud;
   // masked-off lanes read as zero, so they act as "no effect"
   wire cmd_t cmd = decode_cmd(wbits);

   // merge masked bytes into the current settings
   wire [31:0] mode_word = {12'h000, mode_r.over, 13'h0000,
                            mode_r.src, 4'h0};
   wire [31:0] mode_merge = (mode_word & ~wmask) | wbits;
   wire [31:0] baud_merge = ({{(32-DIV_WIDTH){1'b0}}, divisor_r}
                             & ~wmask) | wbits;

   // ----------------------------------------
   // write channels
   // ----------------------------------------

   // address and data are taken in either order, each once
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         aw_got_r <= 1'b0;
         awready_r <= 1'b0;
         awaddr_r <= 32'h0000_0000;
      end else if (CLK_EN) begin
         if (aw_fire) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= AWADDR;
         end else if (wr_apply) begin
            aw_got_r <= 1'b0;
         end else begin
            awready_r <= (wr_state_r == WR_IDLE) & ~aw_got_r;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         w_got_r <= 1'b0;
         wready_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (CLK_EN) begin
         if (w_fire) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
         end else if (wr_apply) begin
            w_got_r <= 1'b0;
         end else begin
            wready_r <= (wr_state_r == WR_IDLE) & ~w_got_r;
         end
      end
   end

   // response follows both halves; unmapped or read-only gets an error
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         wr_state_r <= WR_IDLE;
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
      end else if (CLK_EN) begin
         case (wr_state_r)
            WR_IDLE: begin
               if (wr_apply) begin
                  wr_state_r <= WR_RESP;
                  bvalid_r <= 1'b1;
                  bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (BREADY) begin
                  wr_state_r <= WR_IDLE;
                  bvalid_r <= 1'b0;
               end
            end
            default: wr_state_r <= WR_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   wire ar_fire = ARVALID & arready_r;
   wire [31:0] stat_word = ({26'h0000000, flags_r})
      | (32'(rx_on_r) << `STAT_RX_ON_BIT)
      | (32'(tx_on_r) << `STAT_TX_ON_BIT);
   // the command word is write-only and reads back as zero
   wire rd_cmd = (ARADDR == `CMD_ADDR);
   wire rd_mode = (ARADDR == `MODE_ADDR);
   wire rd_stat = (ARADDR == `STAT_ADDR);
   wire rd_baud = (ARADDR == `BAUD_ADDR);
   wire rd_ok = rd_cmd | rd_mode | rd_stat | rd_baud;
   wire [31:0] rd_word = rd_mode ? mode_word :
                         rd_stat ? stat_word :
                         rd_baud ? 32'(divisor_r) : 32'h0000_0000;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `RESP_OKAY;
      end else if (CLK_EN) begin
         if (ar_fire) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_r && RREADY) begin
            rvalid_r <= 1'b0;
         end else begin
            arready_r <= ~rvalid_r;
         end
      end
   end

   // ----------------------------------------
   // settings and command actions
   // ----------------------------------------

   // disable beats enable when both arrive in one write
   wire rx_on_nxt = cmd_go & cmd.rx_off ? 1'b0 :
                    cmd_go & cmd.rx_on ? 1'b1 : rx_on_r;
   wire tx_on_nxt = cmd_go & cmd.tx_off ? 1'b0 :
                    cmd_go & cmd.tx_on ? 1'b1 : tx_on_r;
   // an event in the clearing cycle survives: set wins
   wire err_flags_t flags_nxt = (flags_r
      & ~{6{cmd_go & cmd.err_clear}}) | ERR_SET;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         mode_r <= `MODE_RESET;
         divisor_r <= `BAUD_RESET;
         rx_on_r <= 1'b0;
         tx_on_r <= 1'b0;
         rx_reset_r <= 1'b0;
         tx_reset_r <= 1'b0;
         flags_r <= '0;
      end else if (CLK_EN) begin
         if (mode_go) begin
            mode_r <= {mode_merge[`OVER_BIT],
                       mode_merge[`SRC_SEL_LSB +: 2]};
         end
         if (baud_go) divisor_r <= baud_merge[DIV_WIDTH-1:0];
         rx_on_r <= rx_on_nxt;
         tx_on_r <= tx_on_nxt;
         rx_reset_r <= cmd_go & cmd.rx_reset;
         tx_reset_r <= cmd_go & cmd.tx_reset;
         flags_r <= flags_nxt;
      end
   end

   // ----------------------------------------
   // baud source selection
   // ----------------------------------------
   logic pin_rise;

   // pin edges pass three stages; the pin must run slow enough
   sck_sync u_sck_sync (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CLK_EN),
      .pin(SCK_IN),
      .rise(pin_rise)
   );

   // free-running prescaler for the divided system clock
   wire pre_tick = (pre_cnt_r == 3'(`SYS_PRESCALE - 1));

   always_ff @(posedge CLK_SYS) begin
      if (SRST) pre_cnt_r <= 3'h0;
      else if (CLK_EN) pre_cnt_r <= pre_cnt_r + 3'h1;
   end

   // select codes 2 and 3 both take the pin
   wire src_tick = (mode_r.src == 2'h0) ? 1'b1 :
                   (mode_r.src == 2'h1) ? pre_tick : pin_rise;

   // ----------------------------------------
   // divider and oversampling
   // ----------------------------------------
   logic div_tick;

   baud_divider #(.WIDTH(DIV_WIDTH)) u_div (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CLK_EN),
      .src_tick(src_tick),
      .divisor(divisor_r),
      .tick(div_tick)
   );

   // the oversampling count runs on across a change, so one span may be short
   wire [3:0] os_limit = mode_r.over ? 4'(`OS_LOW - 1) :
                                       4'(`OS_HIGH - 1);
   wire os_end = (os_cnt_r >= os_limit);

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         os_cnt_r <= 4'h0;
         sample_r <= 1'b0;
         baud_r <= 1'b0;
      end else if (CLK_EN) begin
         sample_r <= div_tick;
         baud_r <= div_tick & os_end;
         if (div_tick) os_cnt_r <= os_end ? 4'h0 : os_cnt_r + 4'h1;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign AWREADY = awready_r;
   assign WREADY = wready_r;
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign ARREADY = arready_r;
   assign RVALID = rvalid_r;
   assign RDATA = rdata_r;
   assign RRESP = rresp_r;
   assign RX_ENABLE = rx_on_r;
   assign TX_ENABLE = tx_on_r;
   assign RX_RESET = rx_reset_r;
   assign TX_RESET = tx_reset_r;
   assign SAMPLE_TICK = sample_r;
   assign BAUD_TICK = baud_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [4:0] span_r;
   logic span_ok_r;

   // sample ticks between baud ticks, valid after a quiet full span
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         span_r <= 5'h00;
         span_ok_r <= 1'b0;
      end else if (CLK_EN) begin
         if (baud_r) span_r <= 5'h00;
         else if (sample_r) span_r <= span_r + 5'h01;
         if (mode_go || baud_go) span_ok_r <= 1'b0;
         else if (baud_r) span_ok_r <= 1'b1;
      end
   end

   AST_RX_OFF: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && cmd_go && cmd.rx_off |=> !RX_ENABLE)
      else $error("receiver not disabled");
   AST_RX_ON: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && cmd_go && cmd.rx_on && !cmd.rx_off |=> RX_ENABLE)
      else $error("receiver not enabled");
   AST_TX_OFF: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && cmd_go && cmd.tx_off |=> !TX_ENABLE)
      else $error("transmitter not disabled");
   AST_TX_ON: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && cmd_go && cmd.tx_on && !cmd.tx_off |=> TX_ENABLE)
      else $error("transmitter not enabled");
   AST_RX_RST: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN |-> ##1 (RX_RESET == $past(cmd_go && cmd.rx_reset)))
      else $error("receiver reset pulse wrong");
   AST_TX_RST: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN |-> ##1 (TX_RESET == $past(cmd_go && cmd.tx_reset)))
      else $error("transmitter reset pulse wrong");
   AST_CLEAR: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && cmd_go && cmd.err_clear |=> flags_r == $past(ERR_SET))
      else $error("error flags not cleared");
   AST_HOLD: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && cmd_go && !cmd.rx_on && !cmd.rx_off && !cmd.tx_on
      && !cmd.tx_off |=> $stable(RX_ENABLE) && $stable(TX_ENABLE))
      else $error("idle command changed enables");
   AST_SAMPLE: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && div_tick |=> SAMPLE_TICK)
      else $error("sampling tick missing");
   AST_SHARED: assert property (@(posedge CLK_SYS) disable iff (SRST)
      BAUD_TICK |-> SAMPLE_TICK)
      else $error("baud tick off the sampling grid");
   AST_SPAN: assert property (@(posedge CLK_SYS) disable iff (SRST)
      CLK_EN && BAUD_TICK && span_ok_r
      |-> span_r + 5'h01 == (mode_r.over ? 5'h08 : 5'h10))
      else $error("oversampling ratio wrong");
   AST_SRC_SYS: assert property (@(posedge CLK_SYS) disable iff (SRST)
      mode_r.src == 2'h1 && src_tick |-> pre_cnt_r == 3'h7)
      else $error("prescaled source off its count");
endmodule

// *** usart_defines.svh ***
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CMD_ADDR 32'h4009_0000
`define MODE_ADDR 32'h4009_0004
`define STAT_ADDR 32'h4009_0014
`define BAUD_ADDR 32'h4009_0020

// ----------------------------------------
// command field positions
// ----------------------------------------
`define RX_RESET_BIT 2
`define TX_RESET_BIT 3
`define RX_ON_BIT 4
`define RX_OFF_BIT 5
`define TX_ON_BIT 6
`define TX_OFF_BIT 7
`define ERR_CLEAR_BIT 8

// ----------------------------------------
// mode, status and divisor layout
// ----------------------------------------
`define SRC_SEL_LSB 4
`define OVER_BIT 19
`define STAT_RX_ON_BIT 8
`define STAT_TX_ON_BIT 9
`define MODE_RESET 3'h0
`define BAUD_RESET 16'h0000

// ----------------------------------------
// clock division counts
// ----------------------------------------
`define SYS_PRESCALE 8
`define OS_HIGH 16
`define OS_LOW 8

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** usart_pkg.sv ***
package usart_pkg;
   // write channel sequencing
   typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;

   // one command word, decoded
   typedef struct packed {
      logic err_clear;
      logic tx_off;
      logic tx_on;
      logic rx_off;
      logic rx_on;
      logic tx_reset;
      logic rx_reset;
   } cmd_t;

   // sticky receive/transmit error flags
   typedef struct packed {
      logic brk;
      logic underrun;
      logic manchester;
      logic overrun;
      logic framing;
      logic parity;
   } err_flags_t;

   // baud source and oversampling choice
   typedef struct packed {
      logic over;
      logic [1:0] src;
   } mode_t;
endpackage
